/* File: tb/module_power_on_sequencer_tb_top.sv */
`timescale 1ns/1ps
module module_power_on_sequencer_tb_top
    import pwr_seq_pkg::*;
;
    // ------------------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------------------
    localparam logic [31:0] LMIN  = 32'h14;
    localparam logic [31:0] PMIN  = 32'h5;
    localparam logic [31:0] PMAX  = 32'h8;
    localparam logic [31:0] RHOLD = 32'h4;
    localparam logic [31:0] CGEN  = 32'h1E;
    localparam logic [31:0] CUSB  = 32'h32;
    localparam logic [31:0] PRESS = 32'h19;
    localparam logic [31:0] CWAIT = 32'h50;
    localparam logic [63:0] RTMO  = 64'h14;
    localparam logic [2:0]  NTRY  = 3'h4;
    localparam logic [31:0] CGAP  = 32'h46;
    logic        clock, arst_n, enable, supply_a, alarm_a, off_a, supply_b, off_b, start, hold_restart;
    logic [7:0]  user_pins;
    logic        core_reset_n_a, generic_a, usb_a, boot_done;
    seq_state_t  state_a, state_b;
    host_state_t host_state;
    int          err_total, samples_checked;
    int          cycles = 0;
    int          lens[5] = '{4, 5, 8, 9, 6};

    pwr_link_if link_a ();
    pwr_link_if link_b ();

    power_on_sequencer #(.VARIANT(variant_level), .LEVEL_MIN(LMIN), .PULSE_MIN(PMIN), .PULSE_MAX(PMAX),
        .RESET_HOLD(RHOLD), .CONFIG_GENERIC(CGEN), .CONFIG_USB(CUSB)) i_power_on_sequencer (
        .clock(clock), .arst_n(arst_n), .enable(enable), .supply_valid(supply_a), .alarm_due(alarm_a),
        .switch_off_command(off_a), .link(link_a.device), .core_reset_n(core_reset_n_a),
        .generic_ready(generic_a), .usb_ready(usb_a), .state(state_a));
    power_on_sequencer #(.VARIANT(variant_pulse), .LEVEL_MIN(LMIN), .PULSE_MIN(PMIN), .PULSE_MAX(PMAX),
        .RESET_HOLD(RHOLD), .CONFIG_GENERIC(CGEN), .CONFIG_USB(CUSB)) i_power_on_sequencer_b (
        .clock(clock), .arst_n(arst_n), .enable(enable), .supply_valid(supply_b), .alarm_due(1'b0),
        .switch_off_command(off_b), .link(link_b.device), .core_reset_n(), .generic_ready(),
        .usb_ready(), .state(state_b));
    power_on_host #(.VARIANT(variant_level), .PRESS_CYCLES(PRESS), .CONFIG_WAIT(CWAIT),
        .REPLY_TIMEOUT(RTMO), .TRIES(NTRY)) i_power_on_host (
        .clock(clock), .arst_n(arst_n), .enable(enable), .start(start), .hold_restart(hold_restart),
        .user_pins(user_pins), .link(link_a.host), .boot_done(boot_done), .state(host_state));
    pwr_link_checker #(.LEVEL_MIN(LMIN), .CMD_GAP(CGAP)) i_pwr_link_checker (
        .clock(clock), .arst_n(arst_n), .power_on_request_n(link_a.power_on_request_n),
        .backup_supply_out(link_a.backup_supply_out), .interface_supply_out(link_a.interface_supply_out),
        .pins_oe(link_a.pins_oe), .host_pins_o(link_a.host_pins_o), .host_pins_oe(link_a.host_pins_oe),
        .at_cmd(link_a.at_cmd), .at_reply(link_a.at_reply));

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // ------------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------------
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask : check

    task automatic ticks(input int n);
        repeat (n) @(negedge clock);
    endtask : ticks

    task automatic wait_state(input logic on_b, input seq_state_t want, input string what);
        int n;
        n = 0;
        while (((on_b ? state_b : state_a) !== want) && n < 400) begin
            @(negedge clock);
            n++;
        end
        check(32'((on_b ? state_b : state_a) === want), 32'h1, what);
    endtask : wait_state

    task automatic switch_off(input logic on_b);
        @(posedge clock);
        off_a <= !on_b;
        off_b <= on_b;
        @(posedge clock);
        off_a <= 1'b0;
        off_b <= 1'b0;
        wait_state(on_b, st_power_off, "off");
        ticks(1);
    endtask : switch_off

    task automatic press_b(input int len);
        @(posedge clock);
        link_b.power_on_request_n <= 1'b0;
        repeat (len) @(posedge clock);
        link_b.power_on_request_n <= 1'b1;
    endtask : press_b

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total++;
            $display("Error at %0t: run did not finish", $time);
            end_of_test();
        end
    end

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        int n;
        int m;
        {arst_n, supply_a, alarm_a, off_a, supply_b, off_b, start, hold_restart} = 8'h00;
        enable = 1'b1;
        user_pins = 8'hA5;
        link_b.power_on_request_n = 1'b1;
        link_b.restart_n_o = 1'b1;
        link_b.restart_n_oe = 1'b1;
        link_b.host_pins_o = 8'h00;
        link_b.host_pins_oe = 8'hFF;
        link_b.at_cmd = 1'b0;
        err_total = 0;
        samples_checked = 0;
        repeat (20) @(posedge clock);
        arst_n <= 1'b1;
        @(posedge clock);
        supply_a <= 1'b1;
        ticks(2);
        check(link_a.backup_supply_out, 1, "backup");
        check(link_a.interface_supply_out, 0, "interface early");
        wait_state(0, st_reset_hold, "hold");
        check(core_reset_n_a, 0, "core reset");
        check(link_a.pins_oe, 8'hFF, "pins in reset");
        check(host_state, h_wait_config, "host saw supply");
        check(link_a.power_on_request_n, 1, "request idle");
        wait_state(0, st_pin_config, "config");
        ticks(1);
        check(core_reset_n_a, 1, "core released");
        check(link_a.pins_oe, 8'h00, "pins driven");
        check(link_a.pins_o, 8'h00, "pin defaults");
        n = 0;
        while (generic_a !== 1'b1 && n < 400) begin
            @(negedge clock);
            n++;
        end
        m = 0;
        while (usb_a !== 1'b1 && m < 400) begin
            @(negedge clock);
            m++;
        end
        check(m, 20, "usb after generic");
        check(state_a, st_running, "running");
        switch_off(0);
        check({link_a.interface_supply_out, link_a.backup_supply_out, link_a.pins_oe}, 10'h1FF, "off");
        @(posedge clock);
        start <= 1'b1;
        @(posedge clock);
        start <= 1'b0;
        n = 0;
        while (boot_done !== 1'b1 && n < 600) begin
            @(negedge clock);
            n++;
        end
        check(boot_done, 1, "boot check");
        check(host_state, h_ready, "host ready");
        check(state_a, st_running, "level start");
        switch_off(0);
        @(posedge clock);
        alarm_a <= 1'b1;
        @(posedge clock);
        alarm_a <= 1'b0;
        wait_state(0, st_running, "alarm start");
        @(posedge clock);
        supply_a <= 1'b0;
        hold_restart <= 1'b1;
        ticks(3);
        check({link_a.backup_supply_out, state_a}, {1'b0, st_not_powered}, "supply gone");
        @(posedge clock);
        supply_a <= 1'b1;
        ticks(20);
        check({link_a.interface_supply_out, state_a}, {1'b0, st_power_off}, "restart held");
        @(posedge clock);
        hold_restart <= 1'b0;
        wait_state(0, st_running, "restart release");
        // The request is held low through supply-up; it must not block the start.
        @(posedge clock);
        link_b.power_on_request_n <= 1'b0;
        supply_b <= 1'b1;
        wait_state(1, st_running, "request ignored");
        @(posedge clock);
        link_b.power_on_request_n <= 1'b1;
        switch_off(1);
        foreach (lens[i]) begin
            press_b(lens[i]);
            ticks(4);
            check(link_b.interface_supply_out, 32'(lens[i] >= PMIN && lens[i] <= PMAX), "pulse");
            if (lens[i] >= PMIN && lens[i] <= PMAX) begin
                wait_state(1, st_running, "pulse start");
                switch_off(1);
            end
        end
        @(posedge clock);
        link_b.restart_n_oe <= 1'b0;
        link_b.restart_n_o <= 1'b0;
        repeat (3) @(posedge clock);
        link_b.restart_n_oe <= 1'b1;
        link_b.restart_n_o <= 1'b1;
        wait_state(1, st_running, "restart pulse");
        @(posedge clock);
        arst_n <= 1'b0;
        ticks(1);
        check(state_a, st_not_powered, "reset again");
        end_of_test();
    end
endmodule : module_power_on_sequencer_tb_top

/* File: tb/pwr_link_checker.sv */
`timescale 1ns/1ps
module pwr_link_checker #(
    parameter logic [31:0] LEVEL_MIN = 32'h14,
    parameter logic [31:0] CMD_GAP   = 32'h46
) (
    input wire logic       clock,
    input wire logic       arst_n,
    input wire logic       power_on_request_n,
    input wire logic       backup_supply_out,
    input wire logic       interface_supply_out,
    input wire logic [7:0] pins_oe,
    input wire logic [7:0] host_pins_o,
    input wire logic [7:0] host_pins_oe,
    input wire logic       at_cmd,
    input wire logic       at_reply
);
    // ------------------------------------------------------------------------
    // Helper counters
    // ------------------------------------------------------------------------
    logic [31:0] low_cnt;
    logic [31:0] up_cnt;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            low_cnt <= 32'h0;
        end else begin
            low_cnt <= power_on_request_n ? 32'h0 : low_cnt + 32'h1;
        end
    end

    // Saturates so a long run never wraps back under the gap.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            up_cnt <= 32'h0;
        end else if (!interface_supply_out) begin
            up_cnt <= 32'h0;
        end else if (up_cnt != 32'hFFFF) begin
            up_cnt <= up_cnt + 32'h1;
        end
    end

    // ------------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    sequence pins_released_8;
        (pins_oe == 8'hFF) [*8];
    endsequence

    sequence cmd_then_idle;
        at_cmd ##1 !at_cmd;
    endsequence

    chk_backup_first: assert property ($rose(interface_supply_out) |-> backup_supply_out)
        else $error("Interface supply rose without backup supply.");
    chk_int_has_backup: assert property (interface_supply_out |-> backup_supply_out)
        else $error("Interface supply on while backup supply off.");
    chk_pins_hiz: assert property (!interface_supply_out |-> pins_oe == 8'hFF)
        else $error("Device pins driven without interface supply.");
    chk_host_quiet: assert property (!interface_supply_out && !$past(interface_supply_out)
        |-> &(host_pins_oe | ~host_pins_o))
        else $error("Host drives pins high before interface supply.");
    chk_reset_hold: assert property ($rose(interface_supply_out) |-> pins_released_8)
        else $error("Pins left reset state too early.");
    chk_press_long: assert property ($rose(power_on_request_n) |-> low_cnt >= LEVEL_MIN)
        else $error("Switch-on request shorter than the minimum.");
    chk_cmd_late: assert property (at_cmd |-> up_cnt >= CMD_GAP)
        else $error("Command sent during configuration.");
    chk_cmd_single: assert property (at_cmd |-> cmd_then_idle)
        else $error("Command pulse longer than one cycle.");
    chk_reply_cause: assert property (at_reply |-> $past(at_cmd))
        else $error("Reply without a command one cycle before.");
endmodule : pwr_link_checker

/* File: verilog/power_on_host.sv */
`timescale 1ns/1ps
`include "pwr_seq_defs.svh"
module power_on_host
    import pwr_seq_pkg::*;
#(
    parameter variant_t    VARIANT       = variant_level,
    parameter logic [31:0] PRESS_CYCLES  = (VARIANT == variant_level) ? `LEVEL_MIN_CYCLES + 32'd250
                                          : (`PULSE_MIN_CYCLES + `PULSE_MAX_CYCLES) / 2,
    parameter logic [31:0] CONFIG_WAIT   = `CONFIG_USB_CYCLES,
    parameter logic [63:0] REPLY_TIMEOUT = `REPLY_TIMEOUT_CYCLES,
    parameter logic [2:0]  TRIES         = `CHECK_TRIES
) (
    input  wire logic        clock,
    input  wire logic        arst_n,
    input  wire logic        enable,
    input  wire logic        start,
    input  wire logic        hold_restart,
    input  wire logic [7:0]  user_pins,
    pwr_link_if.host         link,
    output logic             boot_done,
    output host_state_t      state
);

    logic [63:0] timer;
    logic [2:0]  tries;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state                   <= h_wait_supply;
            timer                   <= 64'h0;
            tries                   <= 3'h0;
            link.power_on_request_n <= 1'b1;
            link.at_cmd             <= 1'b0;
            boot_done               <= 1'b0;
        end else if (enable) begin
            link.at_cmd <= 1'b0;
            unique case (state)
                h_wait_supply: begin
                    link.power_on_request_n <= 1'b1;
                    timer <= 64'h0;
                    if (link.interface_supply_out)
                        state <= h_wait_config;
                    else if (start)
                        state <= h_request;
                end
                h_request: begin
                    link.power_on_request_n <= 1'b0;
                    timer <= timer + 64'h1;
                    if (timer + 64'h1 >= 64'(PRESS_CYCLES)) begin
                        link.power_on_request_n <= 1'b1;
                        timer <= 64'h0;
                        state <= h_wait_supply;
                    end
                end
                h_wait_config: begin
                    timer <= timer + 64'h1;
                    if (!link.interface_supply_out) begin
                        state <= h_wait_supply;
                    end else if (timer + 64'h1 >= 64'(CONFIG_WAIT)) begin
                        timer <= 64'h0;
                        tries <= 3'h0;
                        state <= h_check;
                    end
                end
                h_check: begin
                    link.at_cmd <= 1'b1;
                    timer       <= 64'h0;
                    state       <= h_wait_reply;
                end
                h_wait_reply: begin
                    timer <= timer + 64'h1;
                    if (link.at_reply || timer + 64'h1 >= REPLY_TIMEOUT) begin
                        tries <= tries + 3'h1;
                        state <= (tries + 3'h1 >= TRIES) ? h_ready : h_check;
                    end
                end
                h_ready: begin
                    boot_done <= 1'b1;
                    if (!link.interface_supply_out) begin
                        boot_done <= 1'b0;
                        state     <= h_wait_supply;
                    end
                end
                default: state <= h_wait_supply;
            endcase
        end
    end

    // Pins stay undriven until the far end's interface supply is up.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            link.host_pins_o  <= 8'h00;
            link.host_pins_oe <= 8'hFF;
            link.restart_n_o  <= 1'b0;
            link.restart_n_oe <= 1'b1;
        end else if (enable) begin
            link.host_pins_o  <= link.interface_supply_out ? user_pins : 8'h00;
            link.host_pins_oe <= link.interface_supply_out ? 8'h00 : 8'hFF;
            link.restart_n_o  <= 1'b0;
            link.restart_n_oe <= !hold_restart;
        end
    end

endmodule : power_on_host

/* File: verilog/power_on_sequencer.sv */
`timescale 1ns/1ps
`include "pwr_seq_defs.svh"
// Contract
// - Variant two: low pulse 50-80 us starts
// - Restart held low at supply, release starts
// - Request level ignored during supply ramp
// - Programmed clock alarm starts from power-off
// - Variant two: restart low pulse starts
// - Host keeps request line firmly high
// - Backup supply enabled before interface supply
// - Variant two: restart high after backup
// - Variant one: restart high after interface
// - Generic pins undriven until interface supply
// - Host keeps pins low/undriven before supply
// - Internal reset held after interface supply
// - Reset release drives pins to defaults
// - Configuration lasts 3 s, USB 5 s
// - Host sends no command during configuration
// - Host boot check: 4 tries, 30 s
// - Host watches interface supply for start
// - Switch-off: pins undriven, backup kept
module power_on_sequencer
    import pwr_seq_pkg::*;
#(
    parameter variant_t    VARIANT        = variant_level,
    parameter logic [31:0] LEVEL_MIN      = `LEVEL_MIN_CYCLES,
    parameter logic [31:0] PULSE_MIN      = `PULSE_MIN_CYCLES,
    parameter logic [31:0] PULSE_MAX      = `PULSE_MAX_CYCLES,
    parameter logic [31:0] RESET_HOLD     = `RESET_HOLD_CYCLES,
    parameter logic [31:0] CONFIG_GENERIC = `CONFIG_GENERIC_CYCLES,
    parameter logic [31:0] CONFIG_USB     = `CONFIG_USB_CYCLES,
    parameter logic [7:0]  PIN_DEFAULTS   = 8'h00
) (
    input  wire logic        clock,
    input  wire logic        arst_n,
    input  wire logic        enable,
    input  wire logic        supply_valid,
    input  wire logic        alarm_due,
    input  wire logic        switch_off_command,
    pwr_link_if.device       link,
    output logic             core_reset_n,
    output logic             generic_ready,
    output logic             usb_ready,
    output seq_state_t       state
);

    // ------------------------------------------------------------------------
    // Pin sampling
    // ------------------------------------------------------------------------
    // The restart line idles high through a pull-up that is only live once its
    // supply is up; before that it reads low unless the host drives it high.
    logic pull_live;
    logic restart_level;
    logic restart_prev;
    logic req_prev;
    logic [31:0] low_count;
    logic [31:0] timer;
    logic restart_held;
    logic configured;

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    // True on the cycle that completes a count of limit cycles.
    function automatic logic reached(input logic [31:0] count, input logic [31:0] limit);
        return (count + 32'h1) >= limit;
    endfunction : reached

    assign pull_live = (VARIANT == variant_pulse) ? link.backup_supply_out
                                                  : link.interface_supply_out;
    assign restart_level = link.restart_n_oe ? pull_live : link.restart_n_o;

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            req_prev     <= 1'b1;
            restart_prev <= 1'b0;
        end else if (enable) begin
            req_prev     <= link.power_on_request_n;
            restart_prev <= restart_level;
        end
    end

    // ------------------------------------------------------------------------
    // Request low-time measurement
    // ------------------------------------------------------------------------
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            low_count <= 32'h0;
        end else if (enable) begin
            if (link.power_on_request_n)
                low_count <= 32'h0;
            else if (low_count != 32'hFFFFFFFF)
                low_count <= low_count + 32'h1;
        end
    end

    logic request_event;
    always_comb begin
        if (VARIANT == variant_level)
            request_event = !link.power_on_request_n && reached(low_count, LEVEL_MIN);
        else
            request_event = link.power_on_request_n && !req_prev
                            && (low_count >= PULSE_MIN) && (low_count <= PULSE_MAX);
    end

    logic restart_rise;
    assign restart_rise = restart_level && !restart_prev;

    // ------------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------------
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state        <= st_not_powered;
            timer        <= 32'h0;
            restart_held <= 1'b0;
        end else if (enable) begin
            if (!supply_valid) begin
                state <= st_not_powered;
                timer <= 32'h0;
            end else begin
                unique case (state)
                    st_not_powered: begin
                        // Request level is not looked at while supply comes up.
                        restart_held <= !restart_level && link.restart_n_oe == 1'b0;
                        if (link.restart_n_oe || restart_level)
                            state <= st_supply_enable;
                        else
                            state <= st_power_off;
                    end
                    st_power_off: begin
                        // The level-variant pull-up is dead here, so a release shows only as the drive going away.
                        if (restart_held && (link.restart_n_oe || restart_rise)) begin
                            restart_held <= 1'b0;
                            state        <= st_supply_enable;
                        end else if (request_event || alarm_due) begin
                            state <= st_supply_enable;
                        end else if (VARIANT == variant_pulse && restart_rise) begin
                            state <= st_supply_enable;
                        end
                        timer <= 32'h0;
                    end
                    st_supply_enable: begin
                        restart_held <= 1'b0;
                        timer <= timer + 32'h1;
                        if (reached(timer, `SUPPLY_STEP_CYCLES)) begin
                            timer <= 32'h0;
                            state <= st_reset_hold;
                        end
                    end
                    st_reset_hold: begin
                        timer <= timer + 32'h1;
                        if (reached(timer, RESET_HOLD)) begin
                            timer <= 32'h0;
                            state <= st_pin_config;
                        end
                    end
                    st_pin_config: begin
                        timer <= timer + 32'h1;
                        if (reached(timer, CONFIG_USB))
                            state <= st_running;
                    end
                    st_running: begin
                        if (switch_off_command)
                            state <= st_power_off;
                    end
                    default: state <= st_not_powered;
                endcase
            end
        end
    end

    // A supply loss must release the pins on the same edge that drops the interface supply.
    assign configured = supply_valid && (state == st_pin_config || state == st_running);

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            link.backup_supply_out    <= 1'b0;
            link.interface_supply_out <= 1'b0;
            link.pins_o               <= 8'h00;
            link.pins_oe              <= 8'hFF;
            link.at_reply             <= 1'b0;
            core_reset_n              <= 1'b0;
            generic_ready             <= 1'b0;
            usb_ready                 <= 1'b0;
        end else if (enable) begin
            link.backup_supply_out    <= supply_valid;
            link.interface_supply_out <= supply_valid && state != st_not_powered
                                         && state != st_power_off;
            core_reset_n              <= configured;
            if (configured) begin
                link.pins_o  <= PIN_DEFAULTS;
                link.pins_oe <= 8'h00;
            end else begin
                link.pins_o  <= 8'h00;
                link.pins_oe <= 8'hFF;
            end
            generic_ready <= configured
                             && (state == st_running || timer >= CONFIG_GENERIC);
            usb_ready     <= configured && state == st_running;
            link.at_reply <= state == st_running && link.at_cmd;
        end
    end

endmodule : power_on_sequencer

/* File: verilog/pwr_link_if.sv */
`timescale 1ns/1ps
interface pwr_link_if;
    logic power_on_request_n;
    logic restart_n_o;
    logic restart_n_oe;
    logic backup_supply_out;
    logic interface_supply_out;
    logic [7:0] pins_o;
    logic [7:0] pins_oe;
    logic [7:0] host_pins_o;
    logic [7:0] host_pins_oe;
    logic at_cmd;
    logic at_reply;

    modport device (
        input  power_on_request_n,
        input  restart_n_o,
        input  restart_n_oe,
        output backup_supply_out,
        output interface_supply_out,
        output pins_o,
        output pins_oe,
        input  host_pins_o,
        input  host_pins_oe,
        input  at_cmd,
        output at_reply
    );

    modport host (
        output power_on_request_n,
        output restart_n_o,
        output restart_n_oe,
        input  backup_supply_out,
        input  interface_supply_out,
        input  pins_o,
        input  pins_oe,
        output host_pins_o,
        output host_pins_oe,
        output at_cmd,
        input  at_reply
    );
endinterface : pwr_link_if

/* File: verilog/pwr_seq_defs.svh */
`ifndef PWR_SEQ_DEFS_SVH
`define PWR_SEQ_DEFS_SVH

// ----------------------------------------------------------------------------
// Timing figures and derived cycle counts
// ----------------------------------------------------------------------------
`define CLOCK_MHZ            250
`define LEVEL_MIN_US         5000
`define PULSE_MIN_US         50
`define PULSE_MAX_US         80
`define RESET_HOLD_US        10
`define CONFIG_GENERIC_MS    3000
`define CONFIG_USB_MS        5000
`define REPLY_TIMEOUT_MS     30000
`define CHECK_TRIES          4
`define SUPPLY_STEP_CYCLES   16
`define LEVEL_MIN_CYCLES     (`LEVEL_MIN_US * `CLOCK_MHZ)
`define PULSE_MIN_CYCLES     (`PULSE_MIN_US * `CLOCK_MHZ)
`define PULSE_MAX_CYCLES     (`PULSE_MAX_US * `CLOCK_MHZ)
`define RESET_HOLD_CYCLES    (`RESET_HOLD_US * `CLOCK_MHZ)
`define CONFIG_GENERIC_CYCLES (`CONFIG_GENERIC_MS * 1000 * `CLOCK_MHZ)
`define CONFIG_USB_CYCLES    (`CONFIG_USB_MS * 1000 * `CLOCK_MHZ)
`define REPLY_TIMEOUT_CYCLES (64'(`REPLY_TIMEOUT_MS) * 1000 * `CLOCK_MHZ)

`endif

/* File: verilog/pwr_seq_pkg.sv */
package pwr_seq_pkg;

    // ------------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------------
    typedef enum logic {
        variant_level,
        variant_pulse
    } variant_t;

    typedef enum logic [2:0] {
        st_not_powered,
        st_power_off,
        st_supply_enable,
        st_reset_hold,
        st_pin_config,
        st_running
    } seq_state_t;

    typedef enum logic [2:0] {
        h_wait_supply,
        h_request,
        h_wait_config,
        h_check,
        h_wait_reply,
        h_ready
    } host_state_t;

endpackage : pwr_seq_pkg
